// *** design/nert_pkg.sv ***
package nert_pkg;

  // ==========================================================================
  // Reference tick and epoch timing
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 50000000;
  localparam int unsigned TICK_HZ        = 1000;
  localparam int unsigned TICK_DIV       = CLK_HZ / TICK_HZ;
  localparam int unsigned EPOCH_NOM_TICK = 1000;
  localparam int unsigned ACQ_PERIOD_MS  = 500;
  localparam logic [13:0] HALF_SEC_MS    = 14'h01f4;
  localparam logic [13:0] SEC_MS         = 14'h03e8;
  localparam logic [3:0]  MAX_SEC_MULT   = 4'ha;
  localparam logic [31:0] WEEK_MS        = 32'h240c8400;

  // ==========================================================================
  // Default conversion offsets used when no parameters are known
  // ==========================================================================
  localparam logic [31:0] DFLT_GPS_OFS_MS = 32'h00000000;
  localparam logic [31:0] DFLT_UTC_OFS_MS = 32'h00004650;

  // ==========================================================================
  // Power save states
  // ==========================================================================
  typedef enum logic [2:0] {
    PS_CONT     = 3'b000,
    PS_ACQ      = 3'b001,
    PS_TRACK    = 3'b011,
    PS_POT      = 3'b010,
    PS_INACTIVE = 3'b110
  } nert_ps_t;

endpackage : nert_pkg

// *** design/nert_tick_div.sv ***
`timescale 1ns/1ps
module nert_tick_div #(
  parameter int unsigned DIV = 50000
) (
  input  wire logic clk_sys_i,
  input  wire logic reset_n_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic         tick_q, tick_d;

  // ==========================================================================
  // Divide the oscillator down to a one-cycle 1 kHz tick.
  // ==========================================================================
  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + W'(1);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;
endmodule : nert_tick_div

// *** design/nert_epoch_sched.sv ***
`timescale 1ns/1ps
module nert_epoch_sched (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        tick_i,
  input  wire logic        run_i,
  input  wire logic [13:0] period_i,
  input  wire logic [1:0]  corr_i,
  output logic             epoch_o
);
  import nert_pkg::*;

  logic [13:0] left_q, left_d;
  logic        ep_q, ep_d;
  logic [13:0] reload;

  // ==========================================================================
  // Down-counter of ticks; the epoch lands on the tick where it expires.
  // corr_i: 01 adds one tick, 11 drops one tick, else nominal.
  // ==========================================================================
  always_comb begin
    reload = period_i;
    if (corr_i == 2'b01) reload = period_i + 14'h0001;
    if (corr_i == 2'b11) reload = period_i - 14'h0001;
    left_d = left_q;
    ep_d   = 1'b0;
    if (!run_i) begin
      left_d = period_i - 14'h0001;
    end else if (tick_i) begin
      if (left_q == 14'h0000) begin
        ep_d   = 1'b1;
        left_d = reload - 14'h0001;
      end else begin
        left_d = left_q - 14'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      left_q <= 14'h0000;
      ep_q   <= 1'b0;
    end else begin
      left_q <= left_d;
      ep_q   <= ep_d;
    end
  end

  assign epoch_o = ep_q;
endmodule : nert_epoch_sched

// *** design/nert_timing_core.sv ***
`timescale 1ns/1ps
// How it works
// - Power save enable refused unless period is 500 ms or 1..10 whole seconds.
// - In power optimized tracking, epochs follow the configured measurement period.
// - In acquisition the epoch rate is fixed at 2 Hz.
// - Per-fix report strobes follow that same 2 Hz rate in acquisition.
// - Tracking and every other active state use the configured period again.
// - Cyclic may fall to on/off on lost fixes unless no-off-entry is set.
// - A 1 kHz tick is divided from the system clock.
// - Epochs and measurements are aligned to tick edges.
// - Before any time reference, local time counts milliseconds since start.
// - First credible time makes local time jump to the estimate.
// - Each solution starts on the tick nearest the desired time.
// - Epoch spacing is nominal, sometimes one tick more or less.
// - Every epoch gives both GPS time and UTC.
// - Missing conversion parameters use defaults and mark the times unverified.
// - Every report of an epoch carries that epoch's time-of-week stamp.
// - Hardware backup and software backup modes both exist.
// - After power-off, stay inactive for the duration or until a wake event.
module nert_timing_core #(
  parameter int unsigned CLK_DIV = nert_pkg::TICK_DIV
) (
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  input  wire logic [13:0]         measurement_period_setting_i,
  input  wire logic                power_save_req_i,
  input  wire logic                cyclic_mode_i,
  input  wire logic                no_off_entry_switch_i,
  input  wire logic                fix_ok_i,
  input  wire logic                fix_lost_i,
  input  wire logic                need_track_i,
  input  wire logic [1:0]          drift_corr_i,
  input  wire logic                time_load_i,
  input  wire logic [31:0]         time_load_ms_i,
  input  wire logic                gps_params_ok_i,
  input  wire logic                utc_params_ok_i,
  input  wire logic [31:0]         gps_ofs_ms_i,
  input  wire logic [31:0]         utc_ofs_ms_i,
  input  wire logic                power_off_request_command_i,
  input  wire logic [31:0]         off_duration_ms_i,
  input  wire logic                wake_event_i,
  input  wire logic                battery_present_i,
  output logic                     power_save_on_o,
  output logic                     cfg_refused_o,
  output nert_pkg::nert_ps_t       ps_state_o,
  output logic                     epoch_o,
  output logic [31:0]              local_time_ms_o,
  output logic                     time_known_o,
  output logic [31:0]              gps_tow_ms_o,
  output logic [31:0]              utc_tow_ms_o,
  output logic                     gps_valid_o,
  output logic                     utc_valid_o,
  output logic [31:0]              epoch_week_time_stamp_o,
  output logic                     position_velocity_time_report_o,
  output logic                     hw_backup_o,
  output logic                     sw_backup_o
);
  import nert_pkg::*;

  // ==========================================================================
  // Period check
  // ==========================================================================
  // Legal measurement period: 500 ms or a whole 1..10 s.
  // A short chain of compares is used instead of a divider, which would cost far more area.
  function automatic logic period_legal(input logic [13:0] p);
    logic ok;
    ok = (p == HALF_SEC_MS);
    for (int k = 1; k <= int'(MAX_SEC_MULT); k++) begin
      if (p == 14'(k) * SEC_MS) ok = 1'b1;
    end
    return ok;
  endfunction : period_legal

  logic        tick;
  logic        epoch;
  logic [13:0] sched_period;
  logic        sched_run;

  // ==========================================================================
  // Tick generation and epoch scheduling
  // ==========================================================================
  // The divider free-runs from reset, so the tick phase is set by reset alone.
  nert_tick_div #(
    .DIV       (CLK_DIV)
  ) u_tick (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .tick_o    (tick)
  );

  // The scheduler takes the correction only at its reload tick, and the period there or on every cycle while stopped.
  nert_epoch_sched u_sched (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .tick_i    (tick),
    .run_i     (sched_run),
    .period_i  (sched_period),
    .corr_i    (drift_corr_i),
    .epoch_o   (epoch)
  );

  // ==========================================================================
  // Power save state
  // ==========================================================================
  nert_ps_t    ps_q, ps_d;
  logic        pse_q, pse_d;
  logic        refused_q, refused_d;
  logic [31:0] off_left_q, off_left_d;
  logic        swb_q, swb_d;

  // Enable is latched only when the period is legal; off-request overrides all state transitions, not the enable.
  // The refusal pulse repeats every cycle the request stands, so the host cannot miss it.
  always_comb begin
    ps_d       = ps_q;
    pse_d      = pse_q;
    refused_d  = 1'b0;
    off_left_d = off_left_q;
    swb_d      = swb_q;
    if (!power_save_req_i) begin
      pse_d = 1'b0;
    end else if (!pse_q) begin
      if (period_legal(measurement_period_setting_i)) begin
        pse_d = 1'b1;
      end else begin
        refused_d = 1'b1;
      end
    end
    case (ps_q)
      // Continuous: go to cyclic tracking or to acquisition once power save is on.
      PS_CONT: begin
        if (pse_q) ps_d = cyclic_mode_i ? PS_POT : PS_ACQ;
      end
      // Acquisition: a good fix moves on to tracking.
      PS_ACQ: begin
        if (!pse_q) ps_d = PS_CONT;
        else if (fix_ok_i) ps_d = PS_TRACK;
      end
      // Tracking: in cyclic operation drop back once no extra tracking is needed.
      PS_TRACK: begin
        if (!pse_q) ps_d = PS_CONT;
        else if (!need_track_i && cyclic_mode_i) ps_d = PS_POT;
      end
      // Power optimized tracking: lost fixes fall to on/off unless the switch forbids it.
      PS_POT: begin
        if (!pse_q) ps_d = PS_CONT;
        else if (fix_lost_i && !no_off_entry_switch_i) ps_d = PS_ACQ;
        else if (need_track_i) ps_d = PS_TRACK;
      end
      PS_INACTIVE: begin
        // Wake on event or once the requested duration runs out.
        if (tick && off_left_q != 32'h00000000) off_left_d = off_left_q - 32'h00000001;
        if (wake_event_i || (off_left_q == 32'h00000000)) begin
          ps_d  = pse_q ? PS_ACQ : PS_CONT;
          swb_d = 1'b0;
        end
      end
      default: ps_d = PS_CONT;
    endcase
    if (power_off_request_command_i) begin
      ps_d       = PS_INACTIVE;
      off_left_d = off_duration_ms_i;
      swb_d      = 1'b1;
    end
  end

  // Power save registers; the core starts in continuous operation.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ps_q       <= PS_CONT;
      pse_q      <= 1'b0;
      refused_q  <= 1'b0;
      off_left_q <= 32'h00000000;
      swb_q      <= 1'b0;
    end else begin
      ps_q       <= ps_d;
      pse_q      <= pse_d;
      refused_q  <= refused_d;
      off_left_q <= off_left_d;
      swb_q      <= swb_d;
    end
  end

  // ==========================================================================
  // Epoch period selection
  // ==========================================================================
  // Acquisition forces 2 Hz; every other active state uses the setting.
  // A new period only takes effect at the next reload, so a change between active states
  // never cuts a running interval short; entering inactive stops the count.
  always_comb begin
    sched_run    = (ps_q != PS_INACTIVE);
    sched_period = measurement_period_setting_i;
    if (ps_q == PS_ACQ) sched_period = 14'(ACQ_PERIOD_MS);
  end

  // ==========================================================================
  // Local time and epoch products
  // ==========================================================================
  logic [31:0] lt_q, lt_d;
  logic        known_q, known_d;
  logic [31:0] gps_q, gps_d;
  logic [31:0] utc_q, utc_d;
  logic        gv_q, gv_d;
  logic        uv_q, uv_d;
  logic [31:0] stamp_q, stamp_d;
  logic        rep_q, rep_d;
  logic        ep_q, ep_d;
  logic [31:0] gofs;
  logic [31:0] uofs;

  // A wrap of the week is ignored here; the offsets are small against a week.
  // Validity flags tell whether the offsets behind a time were known, not only
  // whether local time itself has been set from outside.
  // Products are captured one cycle after the epoch tick and hold until the next.
  always_comb begin
    gofs    = gps_params_ok_i ? gps_ofs_ms_i : DFLT_GPS_OFS_MS;
    uofs    = utc_params_ok_i ? utc_ofs_ms_i : DFLT_UTC_OFS_MS;
    lt_d    = lt_q;
    known_d = known_q;
    if (time_load_i) begin
      lt_d    = time_load_ms_i;
      known_d = 1'b1;
    end else if (tick) begin
      lt_d = (known_q && lt_q == WEEK_MS - 32'h00000001) ? 32'h00000000
                                                         : lt_q + 32'h00000001;
    end
    gps_d   = gps_q;
    utc_d   = utc_q;
    gv_d    = gv_q;
    uv_d    = uv_q;
    stamp_d = stamp_q;
    ep_d    = epoch;
    rep_d   = epoch;
    if (epoch) begin
      gps_d   = lt_q + gofs;
      utc_d   = lt_q + gofs - uofs;
      gv_d    = known_q && gps_params_ok_i;
      uv_d    = known_q && utc_params_ok_i;
      stamp_d = lt_q + gofs;
    end
  end

  // Time registers; local time restarts from zero on every reset.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lt_q    <= 32'h00000000;
      known_q <= 1'b0;
      gps_q   <= 32'h00000000;
      utc_q   <= 32'h00000000;
      gv_q    <= 1'b0;
      uv_q    <= 1'b0;
      stamp_q <= 32'h00000000;
      rep_q   <= 1'b0;
      ep_q    <= 1'b0;
    end else begin
      lt_q    <= lt_d;
      known_q <= known_d;
      gps_q   <= gps_d;
      utc_q   <= utc_d;
      gv_q    <= gv_d;
      uv_q    <= uv_d;
      stamp_q <= stamp_d;
      rep_q   <= rep_d;
      ep_q    <= ep_d;
    end
  end

  // ==========================================================================
  // Backup indication
  // ==========================================================================
  // Hardware backup is only offered while the battery keeps its supply.
  logic hwb_q, hwb_d;
  always_comb begin
    hwb_d = battery_present_i && (ps_q == PS_INACTIVE);
  end

  // Registered so the indication never glitches with the state decode.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hwb_q <= 1'b0;
    end else begin
      hwb_q <= hwb_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a plain copy of a register, with no logic after the flop.
  assign power_save_on_o                 = pse_q;
  assign cfg_refused_o                   = refused_q;
  assign ps_state_o                      = ps_q;
  assign epoch_o                         = ep_q;
  assign local_time_ms_o                 = lt_q;
  assign time_known_o                    = known_q;
  assign gps_tow_ms_o                    = gps_q;
  assign utc_tow_ms_o                    = utc_q;
  assign gps_valid_o                     = gv_q;
  assign utc_valid_o                     = uv_q;
  assign epoch_week_time_stamp_o         = stamp_q;
  assign position_velocity_time_report_o = rep_q;
  assign hw_backup_o                     = hwb_q;
  assign sw_backup_o                     = swb_q;
endmodule : nert_timing_core

// *** sim/nert_timing_core_assertions.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker for the timing core
// ==========================================================
module nert_chk #(
  parameter int unsigned CLK_DIV = 10
) (
  input wire logic               clk_sys_i,
  input wire logic               reset_n_i,
  input wire logic [13:0]        measurement_period_setting_i,
  input wire logic               power_save_req_i,
  input wire logic               gps_params_ok_i,
  input wire logic               utc_params_ok_i,
  input wire logic [31:0]        utc_ofs_ms_i,
  input wire logic               power_off_request_command_i,
  input wire logic               wake_event_i,
  input wire logic               power_save_on_o,
  input wire logic               cfg_refused_o,
  input wire nert_pkg::nert_ps_t ps_state_o,
  input wire logic               epoch_o,
  input wire logic               time_known_o,
  input wire logic [31:0]        gps_tow_ms_o,
  input wire logic [31:0]        utc_tow_ms_o,
  input wire logic               gps_valid_o,
  input wire logic [31:0]        epoch_week_time_stamp_o,
  input wire logic               position_velocity_time_report_o
);
  import nert_pkg::*;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic legal;
  // Power save accepts only half a second or whole seconds from one to ten.
  assign legal = (measurement_period_setting_i == HALF_SEC_MS) || (measurement_period_setting_i != 14'h0000 &&
    measurement_period_setting_i % SEC_MS == 14'h0000 && measurement_period_setting_i <= SEC_MS * MAX_SEC_MULT);
  refuse_bad_a: assert property (power_save_req_i && !legal |=> cfg_refused_o)
    else $error("illegal period not refused");
  accept_good_a: assert property (power_save_req_i && legal |=> !cfg_refused_o)
    else $error("legal period refused");
  pse_cause_a: assert property ($rose(power_save_on_o) |-> $past(power_save_req_i) && $past(legal))
    else $error("power save on without legal request");
  report_epoch_a: assert property (position_velocity_time_report_o == epoch_o)
    else $error("report not coincident with epoch");
  stamp_same_a: assert property (epoch_o |-> epoch_week_time_stamp_o == gps_tow_ms_o)
    else $error("stamp differs from gps time");
  utc_conv_a: assert property (epoch_o && utc_params_ok_i && time_known_o |->
    utc_tow_ms_o == gps_tow_ms_o - utc_ofs_ms_i)
    else $error("utc conversion wrong");
  gps_flag_a: assert property (epoch_o && !gps_params_ok_i |-> !gps_valid_o)
    else $error("gps time flagged valid without parameters");
  epoch_pulse_a: assert property (epoch_o |=> !epoch_o)
    else $error("epoch longer than one cycle");
  off_enter_a: assert property (power_off_request_command_i |=> ps_state_o == PS_INACTIVE)
    else $error("power-off request ignored");
  wake_up_a: assert property (ps_state_o == PS_INACTIVE && wake_event_i |-> ##[1:2] ps_state_o != PS_INACTIVE)
    else $error("wake event ignored");
  cover property (epoch_o && ps_state_o == PS_ACQ);
  cover property (cfg_refused_o);
  cover property (ps_state_o == PS_INACTIVE ##1 ps_state_o != PS_INACTIVE);
endmodule : nert_chk

bind nert_timing_core nert_chk #(.CLK_DIV(CLK_DIV)) u_chk (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
  .measurement_period_setting_i(measurement_period_setting_i), .power_save_req_i(power_save_req_i),
  .gps_params_ok_i(gps_params_ok_i), .utc_params_ok_i(utc_params_ok_i), .utc_ofs_ms_i(utc_ofs_ms_i),
  .power_off_request_command_i(power_off_request_command_i), .wake_event_i(wake_event_i),
  .power_save_on_o(power_save_on_o), .cfg_refused_o(cfg_refused_o), .ps_state_o(ps_state_o),
  .epoch_o(epoch_o), .time_known_o(time_known_o), .gps_tow_ms_o(gps_tow_ms_o), .utc_tow_ms_o(utc_tow_ms_o),
  .gps_valid_o(gps_valid_o), .epoch_week_time_stamp_o(epoch_week_time_stamp_o),
  .position_velocity_time_report_o(position_velocity_time_report_o));

// *** sim/nert_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Host model: issues power-off requests and counts reports
// ==========================================================
module nert_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        sleep_i,
  input  wire logic [31:0] dur_i,
  input  wire logic        report_i,
  output logic             off_cmd_o,
  output logic [31:0]      off_dur_o,
  output int               n_reports_o
);
  // The duration is only valid with the command; otherwise it keeps flipping so a stale read shows.
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      off_cmd_o   <= 1'b0;
      off_dur_o   <= 32'h00000000;
      n_reports_o <= 0;
    end else begin
      off_cmd_o   <= sleep_i;
      off_dur_o   <= sleep_i ? dur_i : ~off_dur_o;
      n_reports_o <= n_reports_o + int'(report_i === 1'b1);
    end
  end
endmodule : nert_host_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the timing core
// ==========================================================
module testbench;
  import nert_pkg::*;
  localparam int unsigned DIV = 10;
  localparam logic [31:0] GOFS = 32'h00000bb8;
  localparam logic [31:0] UOFS = 32'h00001000;
  logic        clk_sys_i, reset_n_i;
  logic [13:0] per;
  logic [1:0]  corr;
  logic [31:0] tv, offd, dur, lt;
  logic        req, cyc, nooff, fok, flost, ntrk, tld, wake, batt, sleep, offc;
  logic        pse, refd, ep, known, rpt, hwb, swb, gok, uok, gv, uv;
  logic [31:0] gps, utc, stamp;
  nert_ps_t    st;
  int          num_errors, n_checks, gap, rcnt;
  int          expq[$];
  logic [13:0] pers[8] = '{14'h01f3, 14'h05dc, 14'h2af8, 14'h0000, 14'h01f4, 14'h03e8, 14'h07d0, 14'h2710};

  nert_timing_core #(.CLK_DIV(DIV)) dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .measurement_period_setting_i(per), .power_save_req_i(req), .cyclic_mode_i(cyc),
    .no_off_entry_switch_i(nooff), .fix_ok_i(fok), .fix_lost_i(flost), .need_track_i(ntrk),
    .drift_corr_i(corr), .time_load_i(tld), .time_load_ms_i(tv), .gps_params_ok_i(gok),
    .utc_params_ok_i(uok), .gps_ofs_ms_i(GOFS), .utc_ofs_ms_i(UOFS),
    .power_off_request_command_i(offc), .off_duration_ms_i(offd), .wake_event_i(wake),
    .battery_present_i(batt), .power_save_on_o(pse), .cfg_refused_o(refd), .ps_state_o(st), .epoch_o(ep),
    .local_time_ms_o(lt), .time_known_o(known), .gps_tow_ms_o(gps), .utc_tow_ms_o(utc), .gps_valid_o(gv),
    .utc_valid_o(uv), .epoch_week_time_stamp_o(stamp), .position_velocity_time_report_o(rpt),
    .hw_backup_o(hwb), .sw_backup_o(swb));

  nert_host_model host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sleep_i(sleep), .dur_i(dur),
    .report_i(rpt), .off_cmd_o(offc), .off_dur_o(offd), .n_reports_o(rcnt));

  // 50 MHz system clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Epoch products from the rules: GPS is local plus offset, UTC is GPS minus offset, defaults if unknown.
  task chk_times(input logic [31:0] lt_exp);
    logic [31:0] g;
    g = lt_exp + (gok ? GOFS : DFLT_GPS_OFS_MS);
    check(gps, g);
    check(stamp, g);
    check(utc, g - (uok ? UOFS : DFLT_UTC_OFS_MS));
    check({gv, uv}, {gok, uok});
  endtask : chk_times

  task end_sim();
    $display("errors %0d, checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task cyc_n(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : cyc_n

  // Returns on the falling edge after the next epoch, so queue notes land before the following one.
  task next_ep();
    @(posedge clk_sys_i iff ep === 1'b1);
    @(negedge clk_sys_i);
  endtask : next_ep

  // Spacing monitor: cycles between epochs are compared with the oldest note, if any.
  always @(posedge clk_sys_i) begin
    if (ep === 1'b1) begin
      if (expq.size() > 0) check(gap, expq.pop_front());
      gap = 1;
    end else gap = gap + 1;
  end

  // Watchdog: the sequence needs well under this many cycles.
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    num_errors++;
    end_sim();
  end

  // Main sequence, inputs moved on falling edges only.
  initial begin
    void'($urandom(32'h0ce9cabd));
    {req, cyc, nooff, fok, flost, ntrk, tld, wake, sleep} = '0;
    {gok, uok} = 2'b01;
    per = 14'h0014;
    corr = 2'b00;
    tv = 32'h00000000;
    dur = 32'h00000000;
    batt = 1'b1;
    gap = 0;
    num_errors = 0;
    n_checks = 0;
    reset_n_i = 1'b0;
    cyc_n(6);
    reset_n_i = 1'b1;
    cyc_n(3);
    check(st, PS_CONT);
    tv = lt;
    cyc_n(100 * DIV);
    check(lt - tv, 32'h00000064);
    check(known, 1'b0);
    // Load just after an epoch, so local time at the following epochs is known exactly.
    next_ep();
    tv = $urandom_range(32'h10000000, 32'h00100000);
    tld = 1'b1;
    cyc_n(1);
    tld = 1'b0;
    cyc_n(2);
    check(known, 1'b1);
    check(lt - tv <= 32'h00000002, 1'b1);
    // The load lands three cycles after an epoch tick, so each of the next three epochs is 20 ticks further on.
    for (int i = 0; i < 4; i++) begin
      corr = i[1:0];
      next_ep();
      if (i < 2) chk_times(tv + 32'(20 * (2 * i + 1)));
      expq.push_back(DIV * (20 + (i == 1) - (i == 3)));
      next_ep();
      {gok, uok} = 2'b10;
    end
    // A left-over correction would be applied again at the next reload and skew acquisition.
    corr = 2'b00;
    cyc = 1'b1;
    foreach (pers[i]) begin
      per = pers[i];
      req = 1'b1;
      cyc_n(2);
      check(refd, i < 4);
      check(pse, i >= 4);
      req = 1'b0;
      cyc_n(4);
    end
    cyc = 1'b0;
    per = 14'h03e8;
    req = 1'b1;
    cyc_n(3);
    check(st, PS_ACQ);
    next_ep();
    tv = rcnt;
    expq.push_back(500 * DIV);
    expq.push_back(500 * DIV);
    next_ep();
    next_ep();
    check(rcnt - tv, 32'h00000002);
    fok = 1'b1;
    cyc_n(1);
    fok = 1'b0;
    cyc_n(2);
    check(st, PS_TRACK);
    next_ep();
    expq.push_back(1000 * DIV);
    next_ep();
    cyc = 1'b1;
    cyc_n(3);
    check(st, PS_POT);
    next_ep();
    expq.push_back(1000 * DIV);
    next_ep();
    for (int i = 0; i < 2; i++) begin
      nooff = (i == 0);
      flost = 1'b1;
      cyc_n(1);
      flost = 1'b0;
      cyc_n(2);
      check(st, i == 0 ? PS_POT : PS_ACQ);
    end
    for (int i = 0; i < 2; i++) begin
      batt = (i == 0);
      dur = (i == 0) ? 32'h0000001e : 32'h00ffffff;
      sleep = 1'b1;
      cyc_n(1);
      sleep = 1'b0;
      cyc_n(2);
      check({st, swb, hwb}, {PS_INACTIVE, 1'b1, i == 0});
      cyc_n(28 * DIV);
      check(st, PS_INACTIVE);
      wake = (i == 1);
      cyc_n(1);
      wake = 1'b0;
      cyc_n(4 * DIV);
      check({st, swb}, {PS_ACQ, 1'b0});
    end
    end_sim();
  end
endmodule : testbench
